/* core/sfspi_dev.sv */
// Purpose: Device end; serial flash command decoder, array and program engine.
// Assumes: Pins are asynchronous to clk_sys and are sampled by it.
// Notes:   Link clock must stay well below clk_sys for edge detection.
// Operation
// RQ1: Respond only while chip select is low.
// RQ2: Capture input bits on rising clock edges.
// RQ3: Shift read data out on falling edges.
// RQ4: Only one party drives each data line.
// RQ5: Lock bit blocks status writes while protected.
// RQ6: Hold low pauses transfer; resume afterwards.
// RQ7: Only clock modes zero and three.
// RQ8: Host keeps clock below maximum rate.
// RQ9: Program writes at most one 256-byte page.
// RQ10: Erase small sector, sector, or chip.
// RQ11: Host allows maximum page program time.
// RQ12: Write suspend reaches standby within limit.
// RQ13: Software reset reaches standby within limit.
// RQ14: Clock level at select picks mode.
// RQ15: Traffic grouped into eight-bit units.
// RQ16: Data outputs released unless sending read data.
module sfspi_dev import sfspi_pkg::*; #(
  parameter int PROG_CYC = PP_TYP_CYC
) (
  input  wire logic clk_sys,   // System clock.
  input  wire logic reset_n,   // Asynchronous reset.
  sfspi_if.dev      link,      // Pins toward the host.
  output logic      standby,   // Deselected and engine quiet.
  output logic      busy,      // Program or erase running.
  output logic      mode3      // Clock mode caught at select.
);
  logic [7:0]    mem [0:MEM_BYTES-1];
  logic [7:0]    pbuf [0:PAGE_BYTES-1];
  logic [255:0]  pbv_r;
  logic [2:0]    cs_q, sck_q, hold_q;
  logic [1:0]    d0_q, wp_q;
  logic          cs_s, hold_s, act, rise, fall, cs_rise, cs_fall, bdone;
  sfspi_phase_t  ph_r;
  sfspi_eng_t    eng_r, susp_from_r;
  logic [7:0]    cmd_r, rx_r, sr_data_r, sh_r, stat_r, src;
  logic [7:0]    rxb;
  logic [2:0]    rx_cnt_r, left_r;
  logic [23:0]   addr_r;
  logic [1:0]    na_r;
  logic          din_r, cmd_ok_r, wel_r, arm_r, dual, tx_on_r;
  logic [7:0]    idx_r;
  logic [11:0]   page_r;
  logic [AW-1:0] ptr_r, ecnt_r;
  logic [31:0]   wait_r;
  logic          eng_busy, idle;

  assign cs_s    = cs_q[1];
  // Hold acts one cycle after the clock edges, so an edge launched with it still counts.
  assign hold_s  = hold_q[2];
  assign act     = !cs_s && hold_s;  // [RQ1] [RQ6]
  assign rise    = act && sck_q[1] && !sck_q[2];
  assign fall    = act && !sck_q[1] && sck_q[2];
  assign cs_rise = cs_q[1] && !cs_q[2];
  assign cs_fall = !cs_q[1] && cs_q[2];
  assign rxb     = {rx_r[6:0], d0_q[1]};
  assign bdone   = rise && (rx_cnt_r == 3'd7);  // [RQ15]
  assign dual    = (cmd_r == OP_DUAL);
  assign eng_busy = (eng_r == E_PROG) || (eng_r == E_WAIT) || (eng_r == E_ERASE);
  assign idle    = (eng_r == E_IDLE);
  assign src     = (cmd_r == OP_RDSR) ? {stat_r[7:2], wel_r, eng_busy} : mem[addr_r[AW-1:0]];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cs_q <= 3'b111; sck_q <= 3'b000; d0_q <= 2'b11; wp_q <= 2'b11; hold_q <= 3'b111;
    end else begin
      cs_q <= {cs_q[1:0], link.cs_n};
      sck_q <= {sck_q[1:0], link.sck};
      d0_q <= {d0_q[0], link.bidir_data_line_zero};
      wp_q <= {wp_q[0], link.wp_n};
      hold_q <= {hold_q[1:0], link.hold_n};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode3 <= 1'b0;
      standby <= 1'b1;
      busy <= 1'b0;
    end else begin
      if (cs_fall) mode3 <= sck_q[1];  // [RQ14] [RQ7]
      standby <= cs_s && !eng_busy;
      busy <= eng_busy;
    end
  end

  // Serial front end: decode bytes and shift read data.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ph_r <= P_CMD; cmd_r <= 8'h00; rx_r <= 8'h00; rx_cnt_r <= 3'd0; addr_r <= 24'h000000;
      na_r <= 2'd0; din_r <= 1'b0; cmd_ok_r <= 1'b0; sr_data_r <= 8'h00; sh_r <= 8'h00;
      left_r <= 3'd0; pbv_r <= '0;
      tx_on_r <= 1'b0;
      link.d_d0_o <= 1'b0; link.d_d0_oe <= 1'b0; link.d_d1_o <= 1'b0; link.d_d1_oe <= 1'b0;
    end else if (cs_s) begin
      // Deselected: back to command phase, lines released. [RQ1] [RQ16]
      ph_r <= P_CMD; rx_cnt_r <= 3'd0; left_r <= 3'd0; na_r <= 2'd0; din_r <= 1'b0;
      link.d_d0_oe <= 1'b0; link.d_d1_oe <= 1'b0;
      tx_on_r <= 1'b0;
      if (!cs_rise) cmd_ok_r <= 1'b0;
    end else begin
      if (!hold_s) begin
        link.d_d0_oe <= 1'b0;  // [RQ6]
        link.d_d1_oe <= 1'b0;
      end else if (tx_on_r && !sck_q[1]) begin
        // Back from hold with the clock low: the held bit is driven again. [RQ6]
        link.d_d1_oe <= 1'b1;
        link.d_d0_oe <= dual;
      end
      if (rise) begin
        rx_r <= rxb;  // [RQ2]
        rx_cnt_r <= rx_cnt_r + 3'd1;
      end
      if (bdone) begin
        case (ph_r)
          P_CMD: begin
            cmd_r <= rxb; cmd_ok_r <= 1'b1;
            case (rxb)
              OP_READ, OP_FAST, OP_DUAL, OP_SMALL_ERASE, OP_BLOCK_ERASE: ph_r <= P_ADDR;
              OP_PP: begin ph_r <= P_ADDR; pbv_r <= '0; end
              OP_RDSR: ph_r <= P_DOUT;
              OP_WRSR: ph_r <= P_DIN;
              default: ph_r <= P_IGN;
            endcase
          end
          P_ADDR: begin
            addr_r <= {addr_r[15:0], rxb};
            na_r <= na_r + 2'd1;
            if (na_r == 2'd2) begin
              if (cmd_r == OP_READ) ph_r <= P_DOUT;
              else if (cmd_r == OP_FAST || dual) ph_r <= P_DUM;
              else if (cmd_r == OP_PP) ph_r <= P_DIN;
              else ph_r <= P_IGN;
            end
          end
          P_DUM: ph_r <= P_DOUT;
          P_DIN: begin
            din_r <= 1'b1;
            if (cmd_r == OP_WRSR) sr_data_r <= rxb;
            else begin
              pbv_r[addr_r[7:0]] <= 1'b1;
              addr_r[7:0] <= addr_r[7:0] + 8'h01;  // [RQ9]
            end
          end
          default: ph_r <= ph_r;
        endcase
      end
      if (fall && ph_r == P_DOUT) begin
        // Two-line read drives both lines, two bits per falling edge. [RQ3] [RQ4] [RQ16]
        link.d_d1_oe <= 1'b1;
        link.d_d0_oe <= dual;
        tx_on_r <= 1'b1;
        if (left_r == 3'd0) begin
          link.d_d1_o <= src[7];
          link.d_d0_o <= src[6];
          sh_r <= dual ? {src[5:0], 2'b00} : {src[6:0], 1'b0};
          left_r <= dual ? 3'd3 : 3'd7;
          if (cmd_r != OP_RDSR) addr_r <= addr_r + 24'h000001;
        end else begin
          link.d_d1_o <= sh_r[7];
          link.d_d0_o <= sh_r[6];
          sh_r <= dual ? {sh_r[5:0], 2'b00} : {sh_r[6:0], 1'b0};
          left_r <= left_r - 3'd1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (bdone && ph_r == P_DIN && cmd_r == OP_PP) pbuf[addr_r[7:0]] <= rxb;
  end

  always_ff @(posedge clk_sys) begin
    if (eng_r == E_PROG && pbv_r[idx_r]) mem[{page_r, idx_r}] <= mem[{page_r, idx_r}] & pbuf[idx_r];
    else if (eng_r == E_ERASE) mem[ptr_r] <= 8'hFF;
  end

  // Command execution at deselect and the program/erase engine.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      eng_r <= E_IDLE; susp_from_r <= E_IDLE; stat_r <= ST_RESET; wel_r <= 1'b0;
      arm_r <= 1'b0; idx_r <= 8'h00; page_r <= 12'h000; ptr_r <= '0; ecnt_r <= '0;
      wait_r <= 32'h00000000;
    end else begin
      case (eng_r)
        E_PROG: begin
          idx_r <= idx_r + 8'h01;
          if (idx_r == 8'hFF) begin
            eng_r <= E_WAIT;
            wait_r <= 32'(PROG_CYC);
          end
        end
        E_WAIT: begin
          wait_r <= wait_r - 32'h00000001;
          if (wait_r == 32'h00000001) eng_r <= E_IDLE;
        end
        E_ERASE: begin
          ptr_r <= ptr_r + 20'h00001;
          ecnt_r <= ecnt_r - 20'h00001;
          if (ecnt_r == 20'h00000) eng_r <= E_IDLE;
        end
        E_IDLE, E_SUSP: eng_r <= eng_r;
        default: eng_r <= E_IDLE;
      endcase
      if (cs_rise && cmd_ok_r) begin
        arm_r <= (cmd_r == OP_RSTE);
        case (cmd_r)
          OP_WREN: if (!eng_busy) wel_r <= 1'b1;
          OP_WRDI: if (!eng_busy) wel_r <= 1'b0;
          OP_WRSR: if (din_r && wel_r && idle) begin
            wel_r <= 1'b0;
            if (!(stat_r[ST_LOCK] && !wp_q[1])) stat_r <= sr_data_r & ST_WMASK;  // [RQ5]
          end
          OP_PP: if (din_r && wel_r && idle) begin
            wel_r <= 1'b0; eng_r <= E_PROG; idx_r <= 8'h00;
            page_r <= addr_r[AW-1:8];  // [RQ9]
          end
          OP_SMALL_ERASE, OP_BLOCK_ERASE: if (na_r == 2'd3 && wel_r && idle) begin
            wel_r <= 1'b0; eng_r <= E_ERASE;  // [RQ10]
            ptr_r <= (cmd_r == OP_SMALL_ERASE) ? {addr_r[AW-1:12], 12'h000}
                                               : {addr_r[AW-1:16], 16'h0000};
            ecnt_r <= (cmd_r == OP_SMALL_ERASE) ? 20'(SSEC_BYTES - 1) : 20'(SEC_BYTES - 1);
          end
          OP_ARRAY_ERASE: if (wel_r && idle) begin
            wel_r <= 1'b0; eng_r <= E_ERASE; ptr_r <= '0;  // [RQ10]
            ecnt_r <= 20'(MEM_BYTES - 1);
          end
          OP_WSUS: if (eng_busy) begin
            susp_from_r <= eng_r;
            eng_r <= E_SUSP;  // [RQ12]
          end
          OP_RESM: if (eng_r == E_SUSP) eng_r <= susp_from_r;
          OP_RST: if (arm_r) begin
            eng_r <= E_IDLE; wel_r <= 1'b0;  // [RQ13]
            susp_from_r <= E_IDLE;
          end
          default: wel_r <= wel_r;
        endcase
      end
    end
  end
endmodule

/* core/sfspi_pkg.sv */
// Purpose: Shared constants and types for the serial flash pin link.
// Assumes: System clock of 250 MHz on both ends.
// Notes:   Opcodes and sizes are those of the flash; counts derive from times.
package sfspi_pkg;
  localparam int SYS_MHZ     = 250;
  localparam int SCK_MAX_MHZ = 70;
  // Least half period of the link clock, in system cycles, rounded up.
  localparam int SCK_HALF_MIN = (SYS_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  localparam int SCK_HALF_DEF = 8;
  localparam int PAGE_BYTES   = 256;
  localparam int SSEC_BYTES   = 4096;
  localparam int SEC_BYTES    = 65536;
  localparam int MEM_BYTES    = 1048576;
  localparam int AW           = 20;
  localparam int PP_TYP_NS    = 300000;
  localparam int PP_MAX_NS    = 500000;
  localparam int SUSP_NS      = 20000;
  localparam int SRST_NS      = 40000;
  localparam int PP_TYP_CYC   = PP_TYP_NS * SYS_MHZ / 1000;
  localparam int PP_MAX_CYC   = PP_MAX_NS * SYS_MHZ / 1000;
  localparam int SUSP_CYC     = SUSP_NS * SYS_MHZ / 1000;
  localparam int SRST_CYC     = SRST_NS * SYS_MHZ / 1000;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DUAL = 8'h3B;
  localparam logic [7:0] OP_SMALL_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_ARRAY_ERASE = 8'h60;
  localparam logic [7:0] OP_PP   = 8'h02;
  localparam logic [7:0] OP_WSUS = 8'hB0;
  localparam logic [7:0] OP_RESM = 8'h30;
  localparam logic [7:0] OP_RSTE = 8'h66;
  localparam logic [7:0] OP_RST  = 8'h99;
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] ST_RESET = 8'h00;
  localparam logic [7:0] ST_WMASK = 8'h9C;
  typedef enum logic [5:0] {
    P_CMD = 6'h01, P_ADDR = 6'h02, P_DUM = 6'h04,
    P_DIN = 6'h08, P_DOUT = 6'h10, P_IGN = 6'h20
  } sfspi_phase_t;
  typedef enum logic [4:0] {
    E_IDLE = 5'h01, E_PROG = 5'h02, E_WAIT = 5'h04, E_ERASE = 5'h08, E_SUSP = 5'h10
  } sfspi_eng_t;
  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_SEL = 5'h02, H_XFER = 5'h04, H_END1 = 5'h08, H_END2 = 5'h10
  } sfspi_hst_t;
  typedef enum logic [4:0] {
    K_CMD = 5'h01, K_ADDR = 5'h02, K_DUM = 5'h04, K_WR = 5'h08, K_RD = 5'h10
  } sfspi_kind_t;
endpackage

/* core/sfspi_if.sv */
// Purpose: Pin bundle between the host controller and the flash device.
// Assumes: Both data lines have a pull-up when neither end drives them.
// Notes:   Line levels are resolved here from the two ends' enables.
interface sfspi_if;
  logic cs_n;
  logic sck;
  logic wp_n;
  logic hold_n;
  logic h_d0_o, h_d0_oe, h_d1_o, h_d1_oe;
  logic d_d0_o, d_d0_oe, d_d1_o, d_d1_oe;
  logic bidir_data_line_zero;
  logic bidir_data_line_one;
  assign bidir_data_line_zero = d_d0_oe ? d_d0_o : (h_d0_oe ? h_d0_o : 1'b1);
  assign bidir_data_line_one  = d_d1_oe ? d_d1_o : (h_d1_oe ? h_d1_o : 1'b1);
  modport host (output cs_n, sck, wp_n, hold_n, h_d0_o, h_d0_oe, h_d1_o, h_d1_oe,
                input bidir_data_line_zero, bidir_data_line_one);
  modport dev (input cs_n, sck, wp_n, hold_n, bidir_data_line_zero, bidir_data_line_one,
               output d_d0_o, d_d0_oe, d_d1_o, d_d1_oe);
endinterface

/* core/sfspi_host.sv */
// Purpose: Host end; runs one framed transfer per go pulse on the pins.
// Assumes: User holds op_* stable while busy; wr_data advances on wr_take.
// Notes:   Link clock is the system clock divided by twice SCK_HALF.
module sfspi_host import sfspi_pkg::*; #(
  parameter int SCK_HALF = SCK_HALF_DEF
) (
  input  wire logic       clk_sys,    // System clock.
  input  wire logic       reset_n,    // Asynchronous reset.
  sfspi_if.host           link,       // Pins toward the device.
  input  wire logic       go,         // Start pulse.
  input  wire logic       op_mode3,   // Idle clock level high.
  input  wire logic [7:0] op_cmd,     // Command byte.
  input  wire logic [23:0] op_addr,   // Address.
  input  wire logic [1:0] op_naddr,   // Address bytes.
  input  wire logic [1:0] op_ndum,    // Dummy bytes.
  input  wire logic [8:0] op_nwr,     // Write data bytes.
  input  wire logic [9:0] op_nrd,     // Read data bytes.
  input  wire logic       op_dual,    // Two-line read phase.
  input  wire logic [7:0] wr_data,    // Next byte to send.
  output logic            wr_take,    // Write byte consumed.
  output logic [7:0]      rd_data,    // Received byte.
  output logic            rd_valid,   // Received byte strobe.
  output logic            busy,       // Transfer running.
  input  wire logic       hold_req,   // Pause request.
  input  wire logic       wp_req      // Assert write protect.
);
  sfspi_hst_t  st_r;
  logic [7:0]  cmd_l, sh_r, rx_r;
  logic [23:0] addr_l;
  logic [1:0]  na_l, nd_l;
  logic [8:0]  nw_l;
  logic        m3_l, dual_l;
  logic [10:0] byte_r, total_l;
  logic [2:0]  bit_r;
  logic [7:0]  half_r;
  logic [1:0]  d0_q, d1_q;
  logic        tick, hold_n_r, cs_n_r, sck_r, d0_r, d0oe_r, wp_n_r;
  logic [7:0]  drv;
  sfspi_kind_t kind;

  function automatic sfspi_kind_t kind_of(input logic [10:0] b);
    if (b == 11'h000) return K_CMD;
    if (b <= 11'(na_l)) return K_ADDR;
    if (b <= 11'(na_l) + 11'(nd_l)) return K_DUM;
    if (b <= 11'(na_l) + 11'(nd_l) + 11'(nw_l)) return K_WR;
    return K_RD;
  endfunction

  function automatic logic [7:0] tx_byte(input logic [10:0] b);
    logic [1:0] s;
    s = na_l - b[1:0];
    case (kind_of(b))
      K_CMD:   return cmd_l;
      K_ADDR:  return (s == 2'd2) ? addr_l[23:16] : (s == 2'd1) ? addr_l[15:8] : addr_l[7:0];
      K_WR:    return wr_data;
      default: return 8'h00;
    endcase
  endfunction

  assign kind = kind_of(byte_r);
  assign drv  = (bit_r == 3'd0) ? tx_byte(byte_r) : sh_r;
  assign tick = (half_r == 8'h00) && hold_n_r;
  assign link.cs_n    = cs_n_r;
  assign link.sck     = sck_r;
  assign link.wp_n    = wp_n_r;
  assign link.hold_n  = hold_n_r;
  assign link.h_d0_o  = d0_r;
  assign link.h_d0_oe = d0oe_r;
  assign link.h_d1_o  = 1'b0;
  assign link.h_d1_oe = 1'b0;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      d0_q <= 2'b11;
      d1_q <= 2'b11;
      hold_n_r <= 1'b1;
      wp_n_r <= 1'b1;
    end else begin
      d0_q <= {d0_q[0], link.bidir_data_line_zero};
      d1_q <= {d1_q[0], link.bidir_data_line_one};
      hold_n_r <= !hold_req;
      wp_n_r <= !wp_req;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      half_r <= 8'h00;
    end else if (st_r == H_IDLE || tick || !hold_n_r) begin
      // After a hold a full half period passes, so the device drives its bit again first. [RQ6]
      half_r <= 8'(SCK_HALF - 1);
    end else begin
      half_r <= half_r - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= H_IDLE; cs_n_r <= 1'b1; sck_r <= 1'b0; d0_r <= 1'b0; d0oe_r <= 1'b0;
      busy <= 1'b0; wr_take <= 1'b0; rd_valid <= 1'b0; rd_data <= 8'h00;
      cmd_l <= 8'h00; addr_l <= 24'h000000; na_l <= 2'd0; nd_l <= 2'd0; nw_l <= 9'h000;
      m3_l <= 1'b0; dual_l <= 1'b0; total_l <= 11'h000; byte_r <= 11'h000;
      bit_r <= 3'd0; sh_r <= 8'h00; rx_r <= 8'h00;
    end else begin
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      case (st_r)
        H_IDLE: begin
          sck_r <= op_mode3;
          if (go) begin
            cmd_l <= op_cmd; addr_l <= op_addr; na_l <= op_naddr; nd_l <= op_ndum;
            nw_l <= op_nwr; m3_l <= op_mode3; dual_l <= op_dual; busy <= 1'b1;
            total_l <= 11'h001 + 11'(op_naddr) + 11'(op_ndum) + 11'(op_nwr) + 11'(op_nrd);
            byte_r <= 11'h000; bit_r <= 3'd0;
            st_r <= H_SEL;
          end
        end
        H_SEL: if (tick) begin
          cs_n_r <= 1'b0;
          st_r <= H_XFER;
          if (!m3_l) begin
            d0_r <= drv[7]; d0oe_r <= 1'b1; sh_r <= {drv[6:0], 1'b0};
          end
        end
        H_XFER: if (tick) begin
          if (!sck_r) begin
            sck_r <= 1'b1;
            bit_r <= bit_r + 3'd1;
            // Read data is sampled at the rising edge, half a period after the device shifted it. [RQ3]
            if (kind == K_RD) rx_r <= dual_l ? {rx_r[5:0], d1_q[1], d0_q[1]} : {rx_r[6:0], d1_q[1]};
            if (bit_r == ((kind == K_RD && dual_l) ? 3'd3 : 3'd7)) begin  // [RQ15]
              bit_r <= 3'd0;
              byte_r <= byte_r + 11'h001;
              if (kind == K_RD) begin
                rd_data <= dual_l ? {rx_r[5:0], d1_q[1], d0_q[1]} : {rx_r[6:0], d1_q[1]};
                rd_valid <= 1'b1;
              end
              if (byte_r == total_l - 11'h001) st_r <= H_END1;
            end
          end else begin
            sck_r <= 1'b0;
            d0_r <= drv[7];
            sh_r <= {drv[6:0], 1'b0};
            // Line zero is released for the whole two-line read, dummy byte included. [RQ4]
            d0oe_r <= !(dual_l && (kind == K_DUM || kind == K_RD));
            if (bit_r == 3'd0 && kind == K_WR) wr_take <= 1'b1;
          end
        end
        H_END1: if (tick) begin
          sck_r <= m3_l;  // [RQ7]
          st_r <= H_END2;
        end
        H_END2: if (tick) begin
          cs_n_r <= 1'b1; d0oe_r <= 1'b0; busy <= 1'b0;
          st_r <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
      if (st_r == H_SEL && tick && !m3_l && kind == K_WR) wr_take <= 1'b1;
    end
  end
endmodule

/* bench/sfspi_assertions.sv */
// Purpose: Pin checks on the link between host and device ends.
// Assumes: All pins are sampled by the common system clock.
// Notes:   Inputs carry the names of the interface signals.
module sfspi_assertions (
  input wire logic clk_sys,  // System clock.
  input wire logic reset_n,  // Asynchronous reset.
  input wire logic cs_n,     // Chip select.
  input wire logic sck,      // Link clock.
  input wire logic hold_n,   // Hold.
  input wire logic h_d0_oe,  // Host drives line zero.
  input wire logic h_d1_oe,  // Host drives line one.
  input wire logic d_d0_oe,  // Device drives line zero.
  input wire logic d_d1_oe,  // Device drives line one.
  input wire logic d_d1_o    // Device data on line one.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_line0_one_driver: assert property (!(d_d0_oe && h_d0_oe))
    else $error("Both ends drive line zero.");
  a_line1_one_driver: assert property (!(d_d1_oe && h_d1_oe))
    else $error("Both ends drive line one.");
  a_host_hands_over: assert property ($rose(d_d0_oe) |-> !$past(h_d0_oe))
    else $error("Device took line zero without a turnaround.");
  a_desel_release: assert property (cs_n [*5] |-> !d_d0_oe && !d_d1_oe)
    else $error("Device drives a line while deselected.");
  a_hold_release: assert property (!hold_n [*5] |-> !d_d0_oe && !d_d1_oe)
    else $error("Device drives a line during hold.");
  a_shift_on_fall: assert property (
    d_d1_oe && ($rose(d_d1_oe) || $changed(d_d1_o)) |-> !sck)
    else $error("Read data changed while the link clock is high.");
  a_sck_high_min: assert property ($rose(sck) |-> sck [*2])
    else $error("Link clock high phase too short.");
  a_sck_low_min: assert property ($fell(sck) |-> !sck [*2])
    else $error("Link clock low phase too short.");
  a_mode_settled: assert property ($fell(cs_n) |-> $stable(sck) [*4])
    else $error("Link clock moved right at selection.");
endmodule

/* bench/testbench.sv */
// Purpose: Drives the host user port against the device end and checks data.
// Assumes: Host link clock half period is SCK_HALF_DEF system cycles.
// Notes:   Device program time is shortened to 50 cycles.
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, a); end end
module testbench import sfspi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        go = 1'b0;
  logic        op_mode3 = 1'b0;
  logic        hold_req = 1'b0;
  logic        wp_req = 1'b0;
  logic [7:0]  op_cmd = 8'h00;
  logic [23:0] op_addr = 24'h000000;
  logic [1:0]  op_naddr = 2'h0;
  logic [1:0]  op_ndum = 2'h0;
  logic [8:0]  op_nwr = 9'h000;
  logic [9:0]  op_nrd = 10'h000;
  logic        op_dual = 1'b0;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic        wr_take, rd_valid, busy, standby, dev_busy, mode3;
  logic [7:0]  wbuf [0:255];
  logic [7:0]  rbuf [0:1023];
  int          widx = 0;
  int          ridx = 0;
  int          rb = 0;
  int          n_fail = 0;
  int          checked = 0;
  sfspi_if link ();
  sfspi_host i_sfspi_host (.clk_sys(clk_sys), .reset_n(reset_n), .link(link), .go(go),
    .op_mode3(op_mode3), .op_cmd(op_cmd), .op_addr(op_addr), .op_naddr(op_naddr),
    .op_ndum(op_ndum), .op_nwr(op_nwr), .op_nrd(op_nrd), .op_dual(op_dual),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .busy(busy), .hold_req(hold_req), .wp_req(wp_req));
  sfspi_dev #(.PROG_CYC(50)) i_sfspi_dev (.clk_sys(clk_sys), .reset_n(reset_n),
    .link(link), .standby(standby), .busy(dev_busy), .mode3(mode3));
  sfspi_assertions i_sfspi_assertions (.clk_sys(clk_sys), .reset_n(reset_n),
    .cs_n(link.cs_n), .sck(link.sck), .hold_n(link.hold_n), .h_d0_oe(link.h_d0_oe),
    .h_d1_oe(link.h_d1_oe), .d_d0_oe(link.d_d0_oe), .d_d1_oe(link.d_d1_oe),
    .d_d1_o(link.d_d1_o));
  assign wr_data = wbuf[widx[7:0]];
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (wr_take === 1'b1) widx <= widx + 1;
    if (rd_valid === 1'b1) begin
      rbuf[ridx[9:0]] <= rd_data;
      ridx <= ridx + 1;
    end
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] c, input logic [23:0] a, input logic [1:0] na,
                      input logic [1:0] nd, input logic [8:0] nw, input logic [9:0] nr,
                      input logic dual, input logic [31:0] wd);
    int k;
    for (k = 0; k < 4; k++) wbuf[8'(widx + k)] = wd[31-8*k -: 8];
    rb = ridx;
    @(posedge clk_sys);
    {op_cmd, op_addr, op_naddr, op_ndum, op_nwr, op_nrd, op_dual} <= {c, a, na, nd, nw, nr, dual};
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    #1;
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k == 20000) begin
      n_fail++;
      end_sim();
    end
    // The device acts on the command a few cycles after it sees the deselect.
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  // Waits for standby high (sb) or device busy low, within lim cycles.
  task automatic wait_dev(input bit sb, input int lim);
    int k;
    k = 0;
    while ((sb ? standby !== 1'b1 : dev_busy !== 1'b0) && k < lim) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k == lim) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    xfer(c, 24'h000000, 2'h0, 2'h0, 9'h000, 10'h000, 1'b0, 32'h00000000);
  endtask
  task automatic stat;
    xfer(OP_RDSR, 24'h000000, 2'h0, 2'h0, 9'h000, 10'h001, 1'b0, 32'h00000000);
  endtask
  task automatic rd2(input logic [7:0] c, input logic [23:0] a, input logic [1:0] nd,
                     input logic dual, input logic [15:0] e);
    xfer(c, a, 2'h3, nd, 9'h000, 10'h002, dual, 32'h00000000);
    `CHK("read byte 0", e[15:8], rbuf[rb[9:0]])
    `CHK("read byte 1", e[7:0], rbuf[10'(rb + 1)])
  endtask
  task automatic wrsr(input logic [7:0] v);
    cmd(OP_WREN);
    xfer(OP_WRSR, 24'h000000, 2'h0, 2'h0, 9'h001, 10'h000, 1'b0, {v, 24'h000000});
    wait_dev(1'b0, 1000);
    stat();
  endtask
  initial begin
    for (int i = 0; i < 256; i++) wbuf[i] = 8'h00;
    repeat (3) @(posedge clk_sys);
    `CHK("reset standby", 1'b1, standby)
    `CHK("reset cs", 1'b1, link.cs_n)
    `CHK("reset mode", 1'b0, mode3)
    reset_n <= 1'b1;
    stat();
    `CHK("status at reset", 8'h00, rbuf[rb[9:0]])
    cmd(OP_WREN);
    stat();
    `CHK("status after enable", 8'h02, rbuf[rb[9:0]])
    xfer(OP_SMALL_ERASE, 24'h001000, 2'h3, 2'h0, 9'h000, 10'h000, 1'b0, 32'h00000000);
    `CHK("erase busy", 1'b1, dev_busy)
    `CHK("erase not standby", 1'b0, standby)
    stat();
    `CHK("status busy bit", 1'b1, rbuf[rb[9:0]][ST_BUSY])
    wait_dev(1'b0, 5000);
    rd2(OP_READ, 24'h001FFE, 2'h0, 1'b0, 16'hFFFF);
    cmd(OP_WREN);
    xfer(OP_PP, 24'h0010FE, 2'h3, 2'h0, 9'h004, 10'h000, 1'b0, 32'h11223344);
    `CHK("program busy", 1'b1, dev_busy)
    wait_dev(1'b0, 1000);
    rd2(OP_READ, 24'h0010FE, 2'h0, 1'b0, 16'h1122);
    rd2(OP_READ, 24'h001000, 2'h0, 1'b0, 16'h3344);
    rd2(OP_READ, 24'h001100, 2'h0, 1'b0, 16'hFFFF);
    @(posedge clk_sys) op_mode3 <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rd2(OP_FAST, 24'h001000, 2'h1, 1'b0, 16'h3344);
    `CHK("mode caught", 1'b1, mode3)
    @(posedge clk_sys) op_mode3 <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rd2(OP_DUAL, 24'h0010FE, 2'h1, 1'b1, 16'h1122);
    `CHK("mode caught", 1'b0, mode3)
    fork
      rd2(OP_READ, 24'h001000, 2'h0, 1'b0, 16'h3344);
      begin
        repeat (600) @(posedge clk_sys);
        hold_req <= 1'b1;
        repeat (100) @(posedge clk_sys);
        hold_req <= 1'b0;
      end
    join
    wrsr(8'h80);
    `CHK("lock set", 1'b1, rbuf[rb[9:0]][ST_LOCK])
    @(posedge clk_sys) wp_req <= 1'b1;
    wrsr(8'h00);
    `CHK("lock kept", 1'b1, rbuf[rb[9:0]][ST_LOCK])
    @(posedge clk_sys) wp_req <= 1'b0;
    wrsr(8'h00);
    `CHK("lock cleared", 1'b0, rbuf[rb[9:0]][ST_LOCK])
    cmd(OP_WREN);
    xfer(OP_SMALL_ERASE, 24'h002000, 2'h3, 2'h0, 9'h000, 10'h000, 1'b0, 32'h00000000);
    cmd(OP_WSUS);
    wait_dev(1'b1, SUSP_CYC);
    `CHK("suspend standby", 1'b1, standby)
    cmd(OP_RESM);
    `CHK("resumed", 1'b0, standby)
    wait_dev(1'b0, 5000);
    cmd(OP_WREN);
    xfer(OP_SMALL_ERASE, 24'h003000, 2'h3, 2'h0, 9'h000, 10'h000, 1'b0, 32'h00000000);
    cmd(OP_RSTE);
    cmd(OP_RST);
    wait_dev(1'b1, SRST_CYC);
    stat();
    `CHK("status after soft reset", 8'h00, rbuf[rb[9:0]])
    end_sim();
  end
endmodule
